// ==== inc/pan_pkg.sv ====
// Purpose: shared constants and types for the autoneg ability register slice
// Assumes: 40 MHz system clock, clause 22 style management frames
// Notes: identity values are parameters of the top module, not held here
package pan_pkg;
  localparam int CLK_NS = 25;
  // register offsets on the management link
  localparam logic [4:0] OFS_ID_LOW = 5'h03;
  localparam logic [4:0] OFS_ADV = 5'h04;
  localparam logic [4:0] OFS_LPA = 5'h05;
  localparam logic [4:0] OFS_GCFG = 5'h10;
  // advertisement word fields
  localparam int ADV_NP = 15;
  localparam int ADV_ACK = 14;
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [15:0] ADV_WMASK = 16'h3fff;
  localparam logic [15:0] LPA_RESET = 16'h0000;
  // global configuration word
  localparam logic [15:0] GCFG_RESET = 16'h0048;
  localparam int GCFG_LED_LSB = 11;
  localparam logic [2:0] GCFG_LED_STRAP = 3'h1;
  localparam logic [15:0] GCFG_WMASK = 16'hffff;
  // reduced interface start fill levels in bits
  localparam logic [4:0] RMII_FILL_HI = 5'h10;
  localparam logic [4:0] RMII_FILL_LO = 5'h04;
  // frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] ADDR_LAST = 5'h09;
  localparam logic [4:0] DATA_LAST = 5'h0f;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  // interrupt pulse on the data line, a least time
  localparam int INT_PULSE_NS = 200;
  localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    MI_IDLE, MI_START, MI_OP, MI_ADDR, MI_TA, MI_DATA
  } pan_mi_state_type;

  typedef struct packed {
    logic link_detect_disable;
    logic repeater_mode_enable;
    logic [2:0] indicator_select;
    logic rsvd_zero;
    logic multi_register_access;
    logic int_on_mdio;
    logic reduced_if_fill_threshold;
    logic far_end_fault_disable;
    logic auto_polarity_disable;
    logic jabber_disable;
    logic [3:0] tx_level;
  } pan_gcfg_type;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } pan_lp_type;

  typedef struct packed {
    logic force_fast_half;
    logic loopback_disable;
    logic [4:0] rmii_fill;
  } pan_mode_type;
endpackage

// ==== verification/pan_regs_monitor.sv ====
// Purpose: port assertions for the autoneg ability register slice
// Assumes: one clk_i domain, synchronous active-low reset
// Notes: strap-driven indicator bits are masked in the reset check
`timescale 1ns/10ps
module pan_regs_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic [4:0] phy_addr_i,
  input wire logic led_strap_i,
  input wire logic an_ack_i,
  input wire logic an_restart_i,
  input wire pan_pkg::pan_lp_type lp_i,
  input wire logic int_event_i,
  input wire logic [15:0] adv_word_o,
  input wire pan_pkg::pan_gcfg_type gcfg_o,
  input wire pan_pkg::pan_mode_type mode_o
);
  import pan_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // derived modes are judged only once the config word has sat still
  sequence cfg_settled;
    $stable(gcfg_o) [*2];
  endsequence
  np_held_zero_a: assert property (adv_word_o[ADV_NP] == 1'b0)
    else $error("next page bit seen set");
  ack_set_a: assert property (an_ack_i |=> adv_word_o[ADV_ACK])
    else $error("acknowledge not set after recognition");
  ack_hold_a: assert property (adv_word_o[ADV_ACK] && !an_restart_i |=> adv_word_o[ADV_ACK])
    else $error("acknowledge lost without restart");
  ack_clear_a: assert property (an_restart_i && !an_ack_i |=> !adv_word_o[ADV_ACK])
    else $error("acknowledge kept over restart");
  repeater_mode_a: assert property (cfg_settled |->
    mode_o.force_fast_half == gcfg_o.repeater_mode_enable
    && mode_o.loopback_disable == gcfg_o.repeater_mode_enable)
    else $error("repeater mode outputs disagree with config");
  fill_select_a: assert property (cfg_settled |-> mode_o.rmii_fill ==
    (gcfg_o.reduced_if_fill_threshold ? RMII_FILL_HI : RMII_FILL_LO))
    else $error("fill level disagrees with threshold bit");
  reset_values_a: assert property ($rose(rst_b_i) |-> adv_word_o == ADV_RESET
    && (gcfg_o & 16'hc7ff) == GCFG_RESET && !mdio_oe_o && mode_o.rmii_fill == RMII_FILL_LO)
    else $error("wrong values after reset");
  drive_start_a: assert property ($rose(mdio_oe_o) |-> mdio_o == 1'b0)
    else $error("data line drive does not start low");
endmodule
bind pan_regs pan_regs_monitor mon (.clk_i, .rst_b_i, .mdc_i, .mdio_i, .mdio_o, .mdio_oe_o,
  .phy_addr_i, .led_strap_i, .an_ack_i, .an_restart_i, .lp_i, .int_event_i, .adv_word_o,
  .gcfg_o, .mode_o);

// ==== verification/pan_sta_model.sv ====
// Purpose: station management controller driving the link clock and data
// Assumes: 25 ns bench clock, link half period of four cycles
// Notes: link clock stands low between frames; data released for reads
`timescale 1ns/10ps
module pan_sta_model (
  input wire logic clk_i,
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  import pan_pkg::*;
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end
  // half of the 200 ns link period, moved on falling edges
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  // whole frame; rd gathers second turnaround bit and 16 data bits
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] f;
    f = {32'hffffffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = '0;
    for (int i = 63; i >= 0; i--) begin
      mdio_oe_o = (op == OP_WR) || (i > 17);
      mdio_o = f[i];
      half();
      mdc_o = 1'b1;
      if (i <= 16) rd = {rd[15:0], mdio_i};
      half();
      mdc_o = 1'b0;
    end
    // release, then let an edge pass so back-to-back frames never
    // assign the enable twice in one time step
    mdio_oe_o = 1'b0;
    @(negedge clk_i);
  endtask
endmodule

// ==== verification/tb_pan_regs.sv ====
// Purpose: self-checking bench for the autoneg ability register slice
// Assumes: frames come from the station model at a 200 ns link period
// Notes: reads queue their expectation; a watcher compares on arrival
`timescale 1ns/10ps
module tb_pan_regs;
  import pan_pkg::*;
  localparam logic [5:0] ID_CO = 6'h11; // arbitrary value
  localparam logic [5:0] ID_PN = 6'h05; // arbitrary value
  localparam logic [3:0] ID_RV = 4'h9; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] phy_addr_i;
  logic an_ack_i = 1'b0;
  logic led_strap_i = 1'b0;
  logic an_restart_i = 1'b0;
  logic int_event_i = 1'b0;
  pan_lp_type lp_i = '0;
  logic mdc, sta_d, sta_oe, dut_d, dut_oe, mdio_w;
  logic [15:0] adv_word_o;
  pan_gcfg_type gcfg_o;
  pan_mode_type mode_o;
  logic [16:0] got;
  logic [16:0] exp_q[$];
  int miscompares = 0;
  int checked = 0;
  event got_ev;
  always #12.5 clk_i = ~clk_i;
  // pull-up wins whenever neither party drives
  assign mdio_w = dut_oe ? dut_d : (sta_oe ? sta_d : 1'b1);
  pan_regs #(.COMPANY_ID(ID_CO), .PART_NUMBER(ID_PN), .REVISION(ID_RV)) dut (
    .clk_i, .rst_b_i, .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(dut_d), .mdio_oe_o(dut_oe),
    .phy_addr_i, .led_strap_i, .an_ack_i, .an_restart_i, .lp_i, .int_event_i,
    .adv_word_o, .gcfg_o, .mode_o);
  pan_sta_model sta (.clk_i, .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(sta_d), .mdio_oe_o(sta_oe));
  task automatic chk(input string what, input logic [16:0] e, input logic [16:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [16:0] e);
    logic [16:0] r;
    exp_q.push_back(e);
    sta.xfer(OP_RD, phy, ra, 16'h0000, r);
    got = r;
    ->got_ev;
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [16:0] r;
    sta.xfer(OP_WR, phy_addr_i, ra, d, r);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // watcher: oldest note against each read word as it arrives
  always @(got_ev) chk("read word", exp_q.pop_front(), got);
  initial begin
    logic [15:0] d;
    int n;
    void'($urandom(77));
    phy_addr_i = 5'($urandom());
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(phy_addr_i, OFS_ID_LOW, {1'b0, ID_CO, ID_PN, ID_RV});
    rd(phy_addr_i, OFS_ADV, {1'b0, ADV_RESET});
    rd(phy_addr_i, OFS_GCFG, {1'b0, GCFG_RESET});
    wr(OFS_ID_LOW, 16'hffff);
    wr(OFS_LPA, 16'hffff);
    rd(phy_addr_i, OFS_ID_LOW, {1'b0, ID_CO, ID_PN, ID_RV});
    rd(phy_addr_i, OFS_LPA, 17'h00000);
    rd(phy_addr_i, 5'h07, 17'h1ffff);
    $display("test reset and read-only done");
    for (n = 0; n < 4; n++) begin
      d = (n == 0) ? 16'hffff : 16'($urandom());
      wr(OFS_ADV, d);
      rd(phy_addr_i, OFS_ADV, {1'b0, d & 16'h3fff});
      chk("adv word", {1'b0, d & 16'h3fff}, {1'b0, adv_word_o});
    end
    pulse(an_ack_i);
    wr(OFS_ADV, 16'h0000);
    rd(phy_addr_i, OFS_ADV, 17'h04000);
    pulse(an_restart_i);
    rd(phy_addr_i, OFS_ADV, 17'h00000);
    $display("test advertisement done");
    for (n = 0; n < 2; n++) begin
      d = (n == 0) ? 16'he7e1 : 16'($urandom()) & 16'he7e1;
      lp_i = '{1'b1, d};
      @(negedge clk_i);
      lp_i.valid = 1'b0;
      rd(phy_addr_i, OFS_LPA, {1'b0, d});
    end
    $display("test partner done");
    d = (16'($urandom()) & 16'hfeff) | 16'h4080;
    wr(OFS_GCFG, d);
    rd(phy_addr_i, OFS_GCFG, {1'b0, d});
    chk("fill level", {12'h000, RMII_FILL_HI}, {12'h000, mode_o.rmii_fill});
    chk("repeater", 17'h3, {15'h0, mode_o.force_fast_half, mode_o.loopback_disable});
    wr(OFS_GCFG, 16'h0100);
    chk("fill level", {12'h000, RMII_FILL_LO}, {12'h000, mode_o.rmii_fill});
    chk("repeater", 17'h0, {15'h0, mode_o.force_fast_half, mode_o.loopback_disable});
    $display("test configuration done");
    pulse(int_event_i);
    for (n = 0; n < 40 && dut_oe !== 1'b1; n++) @(negedge clk_i);
    if (n == 40) begin
      miscompares++;
      print_verdict();
    end
    for (n = 0; n < 20 && dut_oe === 1'b1 && dut_d === 1'b0; n++) @(negedge clk_i);
    chk("pulse length", 17'd8, 17'(n));
    wr(OFS_GCFG, 16'h0000);
    pulse(int_event_i);
    n = 0;
    repeat (40) @(negedge clk_i) if (dut_oe !== 1'b0) n++;
    chk("quiet line", 17'd0, 17'(n));
    $display("test interrupt done");
    // mid-run reset with the strap high: indicator field takes the strap code
    led_strap_i = 1'b1;
    rst_b_i = 1'b0;
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(phy_addr_i, OFS_GCFG, {1'b0, GCFG_RESET | (16'(GCFG_LED_STRAP) << GCFG_LED_LSB)});
    rd(phy_addr_i, OFS_LPA, 17'h00000);
    rd(phy_addr_i, OFS_ADV, {1'b0, ADV_RESET});
    $display("test strap reset done");
    repeat (2) @(negedge clk_i);
    print_verdict();
  end
endmodule

// ==== verilog/pan_int_pulse.sv ====
// Purpose: interrupt pulse on the idle management data line
// Assumes: idle_i is high only while no frame is in progress
// Notes: a pending event is dropped while signalling is disabled
`timescale 1ns/10ps
module pan_int_pulse (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic event_i,
  input wire logic enable_i,
  input wire logic idle_i,
  output logic drive_o
);
  import pan_pkg::*;
  typedef struct packed {
    logic pending;
    logic [7:0] cnt;
  } pan_ip_type;
  pan_ip_type s_reg;
  pan_ip_type s_next;
  logic start;

  // new event wins over the clear at pulse start
  always_comb begin
    start = enable_i && idle_i && s_reg.pending && (s_reg.cnt == 8'h00);
    s_next = s_reg;
    s_next.pending = enable_i && (event_i || (s_reg.pending && !start));
    if (start) begin
      s_next.cnt = 8'(INT_PULSE_CYC);
    end else if (s_reg.cnt != 8'h00) begin
      s_next.cnt = s_reg.cnt - 8'h01;
    end
    if (!rst_b_i) begin
      s_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign drive_o = (s_reg.cnt != 8'h00);
endmodule

// ==== verilog/pan_regs.sv ====
// Purpose: per-channel id, advertisement, partner and global config words
// Assumes: management clock and data pins are asynchronous to clk_i
// Notes: unmapped registers are left undriven for other slices
`timescale 1ns/10ps
// Operation
// RQ1: id word read-only: company, part, revision
// RQ2: both ability words shift bit 15 first
// RQ3: acknowledge bit read-only, set on recognition
// RQ4: remote fault bit writable, resets to zero
// RQ5: pause bit writable, resets to zero
// RQ6: four-pair bit writable, resets to zero
// RQ7: fast full duplex bit writable, resets one
// RQ8: fast half duplex bit writable, resets one
// RQ9: slow full duplex bit writable, resets one
// RQ10: slow half duplex bit writable, resets one
// RQ11: selector resets one; reserved bits writable zero
// RQ12: partner word read-only, resets to zero
// RQ13: partner bit 8 follows fast full duplex
// RQ14: partner bit 7 follows fast half duplex
// RQ15: partner slow abilities and selector reflected
// RQ16: global config word fully read/write
// RQ17: repeater mode forces fast half, no loopback
// RQ18: optional interrupt pulse on idle data line
// RQ19: reduced interface starts at 16 or 4
// RQ20: next page held zero, base page only
// RQ21: writes to read-only bits are ignored
module pan_regs #(
  parameter logic [5:0] COMPANY_ID = 6'h2a, // arbitrary value
  parameter logic [5:0] PART_NUMBER = 6'h15, // arbitrary value
  parameter logic [3:0] REVISION = 4'h3 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] phy_addr_i,
  input wire logic led_strap_i,
  input wire logic an_ack_i,
  input wire logic an_restart_i,
  input wire pan_pkg::pan_lp_type lp_i,
  input wire logic int_event_i,
  output logic [15:0] adv_word_o,
  output pan_pkg::pan_gcfg_type gcfg_o,
  output pan_pkg::pan_mode_type mode_o
);
  import pan_pkg::*;

  typedef struct packed {
    pan_mi_state_type st;
    logic [5:0] pre_cnt;
    logic [4:0] bit_cnt;
    logic [1:0] op;
    logic [9:0] addr;
    logic [15:0] sh;
    logic rd_hit;
    logic mdc_q;
    logic mdio;
    logic oe;
    logic [15:0] adv;
    logic [15:0] lpa;
    pan_gcfg_type gcfg;
    pan_mode_type mode;
  } pan_st_type;

  pan_st_type s_reg;
  pan_st_type s_next;
  logic [7:0] pins_sync;
  logic mdc_s;
  logic mdio_s;
  logic strap_s;
  logic [4:0] phy_s;
  logic mdc_rise;
  logic pulse_drv;
  logic idle;
  logic own_phy;
  logic mapped;
  logic [15:0] id_word;

  // merge written value into writable bits only
  function automatic logic [15:0] wr_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [15:0] mask
  );
    wr_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  // is the register address one this slice owns
  function automatic logic is_mapped(input logic [4:0] ra);
    is_mapped = (ra == OFS_ID_LOW) || (ra == OFS_ADV) ||
                (ra == OFS_LPA) || (ra == OFS_GCFG);
  endfunction

  // management clock, data, strap and address pins pass two flops before any logic sees them
  pan_sync2 #(
    .W(8)
  ) u_sync (
    .clk_i(clk_i),
    .d_i({mdc_i, mdio_i, led_strap_i, phy_addr_i}),
    .q_o(pins_sync)
  );

  assign mdc_s = pins_sync[7];
  assign mdio_s = pins_sync[6];
  assign strap_s = pins_sync[5];
  assign phy_s = pins_sync[4:0];

  // interrupt pulse may only start between frames
  pan_int_pulse u_pulse (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .event_i(int_event_i),
    .enable_i(s_reg.gcfg.int_on_mdio), // RQ18
    .idle_i(idle),
    .drive_o(pulse_drv)
  );

  // line idle: no frame in progress and nobody pulling low
  assign idle = (s_reg.st == MI_IDLE) && mdio_s && !s_reg.rd_hit;
  assign mdc_rise = mdc_s && !s_reg.mdc_q;
  assign own_phy = (s_reg.addr[9:5] == phy_s);
  assign mapped = is_mapped(s_reg.addr[4:0]);
  assign id_word = {COMPANY_ID, PART_NUMBER, REVISION}; // RQ1

  // frame decoder, register file and autoneg updates
  always_comb begin
    s_next = s_reg;
    s_next.mdc_q = mdc_s;
    if (mdc_rise) begin
      unique case (s_reg.st)
        MI_IDLE: begin
          // a pulse of our own must not count as a start bit
          if (pulse_drv || s_reg.oe) begin
            s_next.pre_cnt = 6'h00;
          end else if (mdio_s) begin
            if (s_reg.pre_cnt != PREAMBLE_LEN) begin
              s_next.pre_cnt = s_reg.pre_cnt + 6'h01;
            end
          end else if (s_reg.pre_cnt == PREAMBLE_LEN) begin
            s_next.st = MI_START;
            s_next.pre_cnt = 6'h00;
          end else begin
            s_next.pre_cnt = 6'h00;
          end
        end
        MI_START: begin
          // second start bit must be one
          s_next.bit_cnt = 5'h00;
          s_next.st = mdio_s ? MI_OP : MI_IDLE;
        end
        MI_OP: begin
          s_next.op = {s_reg.op[0], mdio_s};
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          if (s_reg.bit_cnt != 5'h00) begin
            s_next.st = MI_ADDR;
            s_next.bit_cnt = 5'h00;
          end
        end
        MI_ADDR: begin
          s_next.addr = {s_reg.addr[8:0], mdio_s};
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          if (s_reg.bit_cnt == ADDR_LAST) begin
            s_next.st = MI_TA;
            s_next.bit_cnt = 5'h00;
          end
        end
        MI_TA: begin
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          if (s_reg.bit_cnt == 5'h00) begin
            // decide once the full address is in
            s_next.rd_hit = (s_reg.op == OP_RD) && own_phy && mapped;
            s_next.sh = 16'h0000;
            unique case (s_reg.addr[4:0])
              OFS_ID_LOW: s_next.sh = id_word;
              OFS_ADV: s_next.sh = s_reg.adv;
              OFS_LPA: s_next.sh = s_reg.lpa;
              OFS_GCFG: s_next.sh = s_reg.gcfg;
              default: s_next.sh = 16'h0000;
            endcase
          end else begin
            s_next.st = MI_DATA;
            s_next.bit_cnt = 5'h00;
            if (s_reg.rd_hit) begin
              // first data bit out is bit 15
              s_next.mdio = s_reg.sh[15]; // RQ2
              s_next.sh = {s_reg.sh[14:0], 1'b0};
            end
          end
        end
        MI_DATA: begin
          s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
          if (s_reg.rd_hit) begin
            s_next.mdio = s_reg.sh[15]; // RQ2
            s_next.sh = {s_reg.sh[14:0], 1'b0};
          end else begin
            // writes arrive bit 15 first as well
            s_next.sh = {s_reg.sh[14:0], mdio_s}; // RQ2
          end
          if (s_reg.bit_cnt == DATA_LAST) begin
            s_next.st = MI_IDLE;
            s_next.pre_cnt = 6'h00;
            s_next.rd_hit = 1'b0;
          end
        end
        default: begin
          s_next.st = MI_IDLE;
        end
      endcase
    end

    // pin drive: read data from turnaround on, else interrupt pulse
    if (s_reg.rd_hit && (s_reg.st == MI_TA || s_reg.st == MI_DATA)) begin
      s_next.oe = 1'b1;
      if (s_reg.st == MI_TA && mdc_rise && s_reg.bit_cnt == 5'h00) begin
        s_next.mdio = 1'b0;
      end
    end else if (s_next.rd_hit) begin
      // turnaround second half: drive low
      s_next.oe = 1'b1;
      s_next.mdio = 1'b0;
    end else begin
      s_next.oe = pulse_drv; // RQ18
      s_next.mdio = 1'b0;
    end

    // write completes on the last data bit; read-only bits are kept
    if (mdc_rise && s_reg.st == MI_DATA && s_reg.bit_cnt == DATA_LAST &&
        s_reg.op == OP_WR && own_phy) begin
      unique case (s_reg.addr[4:0])
        OFS_ADV: begin
          // mask keeps next page and acknowledge out of reach
          s_next.adv = wr_merge(s_reg.adv, {s_reg.sh[14:0], mdio_s},
                                ADV_WMASK); // RQ4 RQ5 RQ6 RQ7 RQ8 RQ9 RQ10 RQ11 RQ21
        end
        OFS_GCFG: begin
          s_next.gcfg = wr_merge(s_reg.gcfg, {s_reg.sh[14:0], mdio_s},
                                 GCFG_WMASK); // RQ16
        end
        default: begin
          // identity and partner words ignore writes
          s_next.adv = s_reg.adv; // RQ21
        end
      endcase
    end

    // acknowledge: recognition sets, restart clears, set wins
    if (an_ack_i) begin
      s_next.adv[ADV_ACK] = 1'b1; // RQ3
    end else if (an_restart_i) begin
      s_next.adv[ADV_ACK] = 1'b0;
    end
    s_next.adv[ADV_NP] = 1'b0; // RQ20

    // partner word loads only from the autoneg engine
    if (lp_i.valid) begin
      s_next.lpa = lp_i.word; // RQ12 RQ13 RQ14 RQ15
    end

    // mode outputs follow the config register
    s_next.mode.force_fast_half = s_next.gcfg.repeater_mode_enable; // RQ17
    s_next.mode.loopback_disable = s_next.gcfg.repeater_mode_enable; // RQ17
    s_next.mode.rmii_fill = s_next.gcfg.reduced_if_fill_threshold ?
                            RMII_FILL_HI : RMII_FILL_LO; // RQ19

    // synchronous reset; indicator field loads from the strap pin
    if (!rst_b_i) begin
      s_next = '0;
      s_next.st = MI_IDLE;
      s_next.adv = ADV_RESET; // RQ3 RQ11
      s_next.lpa = LPA_RESET; // RQ12
      s_next.gcfg = GCFG_RESET;
      if (strap_s) begin
        s_next.gcfg.indicator_select = GCFG_LED_STRAP;
      end
      s_next.mode.rmii_fill = RMII_FILL_LO; // RQ19
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  // outputs straight from flops
  assign mdio_o = s_reg.mdio;
  assign mdio_oe_o = s_reg.oe;
  assign adv_word_o = s_reg.adv; // RQ20
  assign gcfg_o = s_reg.gcfg;
  assign mode_o = s_reg.mode;
endmodule

// ==== verilog/pan_sync2.sv ====
// Purpose: two-flop synchroniser for pins entering the clk_i domain
// Assumes: inputs are levels, each bit treated on its own
// Notes: only the second stage may be read outside
`timescale 1ns/10ps
module pan_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  import pan_pkg::*;
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } pan_sync_type;
  pan_sync_type s_reg;
  pan_sync_type s_next;

  // first stage feeds only the second; no reset, so a strap sampled
  // while reset is held still reaches the reset branch downstream
  always_comb begin
    s_next.meta = d_i;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign q_o = s_reg.stable;
endmodule
